// >>> hw/ops_power_reset.sv
// display driver power and reset-state block: APB register file, init-pin defaults,
// supply settle and discharge timers
// assumes pins arrive asynchronous to CORE_CLK and an APB master on CORE_CLK
//
// Function
// [RULE_01] The host powers up in order: operating and io supplies, display off, init, clear, high supply, wait, display on.
// [RULE_02] The host waits 200 ms after the high display supply is stable before commanding display on.
// [RULE_03] The host powers down with display off, then high supply off, then the operating and io supplies.
// [RULE_04] The host waits 100 ms after removing the high supply before removing the operating and io supplies.
// [RULE_05] The host leaves the high supply floating when it is off and never grounds it.
// [RULE_06] While the active-low init input is low the driver initializes with the display off.
// [RULE_07] On reset the 480 by 128 display mode is selected.
// [RULE_08] On reset segment and common mapping are normal, first outputs at address zero.
// [RULE_09] On reset the display start line is memory address zero.
// [RULE_10] On reset the column address counter is zero.
// [RULE_11] On reset the common outputs scan in the normal direction.
// [RULE_12] On reset the contrast setting is 7F hex.
// [RULE_13] The host should reset the display if noise corrupts the shown window.
`default_nettype none

module ops_power_reset #(
   parameter int unsigned HS_WAIT_CYC   = ops_pkg::OPS_HS_WAIT_CYC,
   parameter int unsigned DISCHARGE_CYC = ops_pkg::OPS_DISCHARGE_CYC,
   parameter int unsigned COLS          = ops_pkg::OPS_COLS
) (
   input  wire logic                            CORE_CLK,
   input  wire logic                            RST,
   input  wire logic                            ACTIVE_LOW_INIT_INPUT_N,
   input  wire logic                            HIGH_SUPPLY_OK,
   input  wire logic                            PSEL,
   input  wire logic                            PENABLE,
   input  wire logic                            PWRITE,
   input  wire logic [ops_pkg::OPS_ADDR_W-1:0]  PADDR,
   input  wire logic [31:0]                     PWDATA,
   input  wire logic [3:0]                      PSTRB,
   output logic                                 PREADY,
   output logic [31:0]                          PRDATA,
   output logic                                 PSLVERR,
   output logic                                 DISPLAY_ON,
   output logic                                 MODE_480,
   output logic                                 SEG_REMAP,
   output logic                                 COM_REMAP,
   output logic                                 SCAN_REV,
   output logic [7:0]                           CONTRAST,
   output logic [ops_pkg::OPS_LINE_W-1:0]       START_LINE,
   output logic [ops_pkg::OPS_COL_W-1:0]        COL_ADDR
);

   if (COLS < 2 || COLS > (1 << ops_pkg::OPS_COL_W)) begin : g_cols_bad
      $error("ops_power_reset: COLS out of range for the column counter");
   end

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   logic                  init_n_m_q;
   logic                  init_n_s_q;
   logic                  hs_m_q;
   logic                  hs_s_q;

   // pins sit at "held in init" and "no high supply" until proven otherwise
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         init_n_m_q <= 1'b0;
         init_n_s_q <= 1'b0;
         hs_m_q     <= 1'b0;
         hs_s_q     <= 1'b0;
      end else begin
         init_n_m_q <= ACTIVE_LOW_INIT_INPUT_N;
         init_n_s_q <= init_n_m_q;
         hs_m_q     <= HIGH_SUPPLY_OK;
         hs_s_q     <= hs_m_q;
      end
   end

   // ****************************************************************
   // supply timers
   // ****************************************************************
   logic                  hs_ready;
   logic                  discharged;

   // [RULE_02] settle wait measured
   ops_delay_timer #(
      .CYCLES (HS_WAIT_CYC)
   ) u_hs_wait (
      .clk    (CORE_CLK),
      .rst    (RST),
      .run    (hs_s_q),
      .done_q (hs_ready)
   );

   // [RULE_04] discharge wait measured
   ops_delay_timer #(
      .CYCLES (DISCHARGE_CYC)
   ) u_discharge (
      .clk    (CORE_CLK),
      .rst    (RST),
      .run    (!hs_s_q),
      .done_q (discharged)
   );

   // ****************************************************************
   // apb decode
   // ****************************************************************
   logic                  pready_q;
   logic                  soft_rst_q;
   logic                  early_on_q;
   ops_pkg::ops_cfg_t     cfg_q;
   ops_pkg::ops_cfg_t     cfg_d;

   // one wait state: commit on the edge where the master sees PREADY
   wire  logic            acc_first = PSEL & PENABLE & ~pready_q;
   wire  logic            fire      = PSEL & PENABLE & pready_q;
   wire  logic            wr_fire   = fire & PWRITE & PSTRB[0];
   wire  logic            sel_ctrl  = (PADDR == ops_pkg::OPS_OFS_CTRL);
   wire  logic            sel_con   = (PADDR == ops_pkg::OPS_OFS_CONTRAST);
   wire  logic            sel_start = (PADDR == ops_pkg::OPS_OFS_START);
   wire  logic            sel_col   = (PADDR == ops_pkg::OPS_OFS_COLADDR);
   wire  logic            sel_stat  = (PADDR == ops_pkg::OPS_OFS_STATUS);
   wire  logic            sel_data  = (PADDR == ops_pkg::OPS_OFS_DATA);
   wire  logic            mapped    = sel_ctrl | sel_con | sel_start | sel_col | sel_stat | sel_data;
   wire  logic            wr_ctrl   = wr_fire & sel_ctrl;
   wire  logic            wr_stat   = wr_fire & sel_stat;

   // [RULE_13] software reset restores defaults
   wire  logic            init_hold = ~init_n_s_q | soft_rst_q;

   // [RULE_02] display-on request before the settle wait is flagged
   wire  logic            early_set = wr_ctrl & PWDATA[ops_pkg::OPS_CTRL_DISP_ON] & ~hs_ready;
   wire  logic            early_clr = wr_stat & PWDATA[ops_pkg::OPS_STAT_EARLY_ON];

   wire  logic [ops_pkg::OPS_COL_W-1:0] col_last = ops_pkg::OPS_COL_W'(COLS - 1);
   wire  logic [ops_pkg::OPS_COL_W-1:0] col_next =
      (cfg_q.col_addr >= col_last) ? '0 : cfg_q.col_addr + ops_pkg::OPS_COL_W'(1);

   wire  logic [31:0]     status_word = {28'h000_0000, early_on_q, discharged, hs_ready, DISPLAY_ON};
   wire  logic [31:0]     ctrl_word   = {26'h000_0000, 1'b0, cfg_q.scan_rev, cfg_q.com_remap,
                                         cfg_q.seg_remap, cfg_q.mode_480, cfg_q.display_on};
   wire  logic [31:0]     rd_word     =
      sel_ctrl  ? ctrl_word :
      sel_con   ? {24'h00_0000, cfg_q.contrast} :
      sel_start ? {25'h000_0000, cfg_q.start_line} :
      sel_col   ? {25'h000_0000, cfg_q.col_addr} :
      sel_stat  ? status_word : 32'h0000_0000;

   // ****************************************************************
   // configuration next value
   // ****************************************************************
   always_comb begin
      cfg_d = cfg_q;
      if (init_hold) begin
         // [RULE_06] [RULE_07] [RULE_08] [RULE_09] [RULE_10] [RULE_11] [RULE_12] defaults loaded
         cfg_d = ops_pkg::OPS_CFG_RESET;
      end else if (wr_fire) begin
         if (sel_ctrl) begin
            cfg_d.display_on = PWDATA[ops_pkg::OPS_CTRL_DISP_ON];
            cfg_d.mode_480   = PWDATA[ops_pkg::OPS_CTRL_MODE_480];
            cfg_d.seg_remap  = PWDATA[ops_pkg::OPS_CTRL_SEG_REMAP];
            cfg_d.com_remap  = PWDATA[ops_pkg::OPS_CTRL_COM_REMAP];
            cfg_d.scan_rev   = PWDATA[ops_pkg::OPS_CTRL_SCAN_REV];
         end
         if (sel_con) begin
            cfg_d.contrast = PWDATA[7:0];
         end
         if (sel_start) begin
            cfg_d.start_line = PWDATA[ops_pkg::OPS_LINE_W-1:0];
         end
         if (sel_col) begin
            cfg_d.col_addr = PWDATA[ops_pkg::OPS_COL_W-1:0];
         end
         // a data write advances the column counter, wrapping at the last column
         if (sel_data) begin
            cfg_d.col_addr = col_next;
         end
      end
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         cfg_q <= ops_pkg::OPS_CFG_RESET;
      end else begin
         cfg_q <= cfg_d;
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         pready_q   <= 1'b0;
         PRDATA     <= 32'h0000_0000;
         PSLVERR    <= 1'b0;
         soft_rst_q <= 1'b0;
         early_on_q <= 1'b0;
      end else begin
         pready_q   <= acc_first;
         PRDATA     <= (acc_first & ~PWRITE) ? rd_word : 32'h0000_0000;
         PSLVERR    <= acc_first & ~mapped;
         soft_rst_q <= wr_ctrl & PWDATA[ops_pkg::OPS_CTRL_SOFT_RST];
         // set wins over a clear in the same cycle
         early_on_q <= early_set | (early_on_q & ~early_clr);
      end
   end

   assign PREADY = pready_q;

   // ****************************************************************
   // panel outputs
   // ****************************************************************
   // light the panel only once the high supply has settled, so a host that ignores
   // the wait cannot stress the panel; the early request is still recorded
   wire  logic            disp_d = ~init_hold & cfg_q.display_on & hs_ready;

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         // [RULE_06] display off from reset
         DISPLAY_ON <= 1'b0;
      end else begin
         DISPLAY_ON <= disp_d;
      end
   end

   assign MODE_480   = cfg_q.mode_480;
   assign SEG_REMAP  = cfg_q.seg_remap;
   assign COM_REMAP  = cfg_q.com_remap;
   assign SCAN_REV   = cfg_q.scan_rev;
   assign CONTRAST   = cfg_q.contrast;
   assign START_LINE = cfg_q.start_line;
   assign COL_ADDR   = cfg_q.col_addr;

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   property p_init_disp_off;
      init_hold |=> !DISPLAY_ON;
   endproperty
   a_init_disp_off: assert property (p_init_disp_off) else $error("display lit while held in init"); // [RULE_06]

   property p_init_mode;
      init_hold |=> MODE_480;
   endproperty
   a_init_mode: assert property (p_init_mode) else $error("wide mode not selected by init"); // [RULE_07]

   property p_init_map;
      init_hold |=> (!SEG_REMAP && !COM_REMAP);
   endproperty
   a_init_map: assert property (p_init_map) else $error("mapping not normal after init"); // [RULE_08]

   property p_init_start;
      $fell(init_hold) |-> (START_LINE == '0);
   endproperty
   a_init_start: assert property (p_init_start) else $error("start line not zero on init release"); // [RULE_09]

   property p_init_col;
      init_hold ##1 !init_hold && !wr_fire |-> (COL_ADDR == '0);
   endproperty
   a_init_col: assert property (p_init_col) else $error("column counter not zero after init"); // [RULE_10]

   property p_init_scan;
      init_hold [*2] |-> !SCAN_REV;
   endproperty
   a_init_scan: assert property (p_init_scan) else $error("scan direction not normal in init"); // [RULE_11]

   property p_init_contrast;
      init_hold |=> (CONTRAST == 8'h7f) ##1 (CONTRAST == 8'h7f || $past(wr_fire));
   endproperty
   a_init_contrast: assert property (p_init_contrast) else $error("contrast not at default after init"); // [RULE_12]

   property p_on_after_wait;
      $rose(DISPLAY_ON) |-> $past(hs_ready) && $past(hs_s_q);
   endproperty
   a_on_after_wait: assert property (p_on_after_wait) else $error("display lit before supply settled"); // [RULE_02]

   property p_off_unsettled;
      !hs_ready |=> !DISPLAY_ON;
   endproperty
   a_off_unsettled: assert property (p_off_unsettled) else $error("display lit without settled supply"); // [RULE_02]

   property p_early_flag;
      early_set |=> early_on_q;
   endproperty
   a_early_flag: assert property (p_early_flag) else $error("early display-on request not recorded"); // [RULE_02]

   property p_discharge_clear;
      hs_s_q |=> !discharged;
   endproperty
   a_discharge_clear: assert property (p_discharge_clear) else $error("discharged shown with supply up"); // [RULE_04]

   property p_soft_defaults;
      soft_rst_q |=> (CONTRAST == ops_pkg::OPS_RST_CONTRAST) && !DISPLAY_ON;
   endproperty
   a_soft_defaults: assert property (p_soft_defaults) else $error("software reset left settings in place"); // [RULE_13]

   c_display_on:  cover property ($rose(DISPLAY_ON));
   c_early_on:    cover property ($rose(early_on_q));
   c_soft_reset:  cover property (soft_rst_q ##1 !init_hold);
   c_discharged:  cover property ($fell(hs_s_q) ##[1:1000] discharged);

endmodule // ops_power_reset

`default_nettype wire

// >>> shared/ops_pkg.sv
// constants and types shared by the panel power and reset-state block
// assumes a single 100 MHz core clock and an APB3/APB4 register bus
`default_nettype none

package ops_pkg;

   // ****************************************************************
   // clock and timing
   // ****************************************************************
   localparam longint unsigned OPS_CLK_HZ         = 100_000_000;
   localparam longint unsigned OPS_HS_WAIT_MS     = 200;
   localparam longint unsigned OPS_DISCHARGE_MS   = 100;
   localparam int unsigned     OPS_HS_WAIT_CYC    = int'((OPS_HS_WAIT_MS * OPS_CLK_HZ) / 1000);
   localparam int unsigned     OPS_DISCHARGE_CYC  = int'((OPS_DISCHARGE_MS * OPS_CLK_HZ) / 1000);

   // ****************************************************************
   // register map, byte addresses
   // ****************************************************************
   localparam int              OPS_ADDR_W         = 12;
   localparam logic [11:0]     OPS_OFS_CTRL       = 12'h000;
   localparam logic [11:0]     OPS_OFS_CONTRAST   = 12'h004;
   localparam logic [11:0]     OPS_OFS_START      = 12'h008;
   localparam logic [11:0]     OPS_OFS_COLADDR    = 12'h00c;
   localparam logic [11:0]     OPS_OFS_STATUS     = 12'h010;
   localparam logic [11:0]     OPS_OFS_DATA       = 12'h014;

   // control register bit positions
   localparam int              OPS_CTRL_DISP_ON   = 0;
   localparam int              OPS_CTRL_MODE_480  = 1;
   localparam int              OPS_CTRL_SEG_REMAP = 2;
   localparam int              OPS_CTRL_COM_REMAP = 3;
   localparam int              OPS_CTRL_SCAN_REV  = 4;
   localparam int              OPS_CTRL_SOFT_RST  = 5;

   // status register bit positions
   localparam int              OPS_STAT_DISP_ON   = 0;
   localparam int              OPS_STAT_HS_READY  = 1;
   localparam int              OPS_STAT_DISCHRG   = 2;
   localparam int              OPS_STAT_EARLY_ON  = 3;

   // ****************************************************************
   // widths and values after reset
   // ****************************************************************
   localparam int              OPS_LINE_W         = 7;
   localparam int              OPS_COL_W          = 7;
   localparam int unsigned     OPS_COLS           = 120;
   localparam logic            OPS_RST_DISP_ON    = 1'b0;
   localparam logic            OPS_RST_MODE_480   = 1'b1;
   localparam logic            OPS_RST_SEG_REMAP  = 1'b0;
   localparam logic            OPS_RST_COM_REMAP  = 1'b0;
   localparam logic            OPS_RST_SCAN_REV   = 1'b0;
   localparam logic [7:0]      OPS_RST_CONTRAST   = 8'h7f;
   localparam logic [6:0]      OPS_RST_START      = 7'h00;
   localparam logic [6:0]      OPS_RST_COLADDR    = 7'h00;

   // ****************************************************************
   // display configuration carrier
   // ****************************************************************
   typedef struct packed {
      logic                    display_on;
      logic                    mode_480;
      logic                    seg_remap;
      logic                    com_remap;
      logic                    scan_rev;
      logic [7:0]              contrast;
      logic [OPS_LINE_W-1:0]   start_line;
      logic [OPS_COL_W-1:0]    col_addr;
   } ops_cfg_t;

   localparam ops_cfg_t OPS_CFG_RESET = '{
      display_on: OPS_RST_DISP_ON,
      mode_480:   OPS_RST_MODE_480,
      seg_remap:  OPS_RST_SEG_REMAP,
      com_remap:  OPS_RST_COM_REMAP,
      scan_rev:   OPS_RST_SCAN_REV,
      contrast:   OPS_RST_CONTRAST,
      start_line: OPS_RST_START,
      col_addr:   OPS_RST_COLADDR
   };

endpackage : ops_pkg

`default_nettype wire

// >>> hw/ops_delay_timer.sv
// consecutive-cycle timer: done rises once run has been high for CYCLES cycles
// assumes run comes from logic on the same clock; a drop of run restarts it
`default_nettype none

module ops_delay_timer #(
   parameter int unsigned CYCLES = 16
) (
   input  wire logic      clk,
   input  wire logic      rst,
   input  wire logic      run,
   output logic           done_q
);

   if (CYCLES < 2) begin : g_cycles_bad
      $error("ops_delay_timer: CYCLES must be at least 2");
   end

   // ****************************************************************
   // counter
   // ****************************************************************
   logic [31:0]           cnt_q;
   logic [31:0]           cnt_d;
   logic                  done_d;
   wire  logic            at_end = (cnt_q == CYCLES - 1);

   assign cnt_d  = !run ? 32'h0000_0000 : (at_end ? cnt_q : cnt_q + 32'h0000_0001);
   assign done_d = run & (at_end | done_q);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q  <= 32'h0000_0000;
         done_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         done_q <= done_d;
      end
   end

endmodule // ops_delay_timer

`default_nettype wire

// >>> verification/ops_host_model.sv
// host-side model: high display supply good flag and the active-low init pin
// assumes bench requests on clk; the supply needs a few cycles to settle
`default_nettype none

module ops_host_model #(
   parameter int unsigned RAMP = 3
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic supply_req,
   input  wire logic init_req,
   output logic      high_supply_ok,
   output logic      init_n
);
   timeunit 1ns;
   timeprecision 1ps;

   int unsigned ramp_q;

   // supply off floats
   // a disabled supply reads as not good at once, never as a driven level
   always_ff @(posedge clk or posedge rst) begin
      if (rst || !supply_req) begin
         ramp_q         <= 0;
         high_supply_ok <= 1'h0;
      end else if (ramp_q < RAMP) begin
         ramp_q <= ramp_q + 1;
      end else begin
         high_supply_ok <= 1'h1;
      end
   end

   assign init_n = !init_req;
endmodule // ops_host_model

`default_nettype wire

// >>> verification/tb_ops_power_reset.sv
// self-checking bench for the panel power and reset-state block
// assumes shortened settle and discharge counts; APB master on clk
`default_nettype none

module tb_ops_power_reset;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int unsigned HS  = 20;
   localparam int unsigned DIS = 10;
   localparam logic [11:0] A_CTRL = ops_pkg::OPS_OFS_CTRL;
   localparam logic [11:0] A_CON  = ops_pkg::OPS_OFS_CONTRAST;
   localparam logic [11:0] A_ST   = ops_pkg::OPS_OFS_START;
   localparam logic [11:0] A_COL  = ops_pkg::OPS_OFS_COLADDR;
   localparam logic [11:0] A_STAT = ops_pkg::OPS_OFS_STATUS;
   localparam logic [11:0] A_DATA = ops_pkg::OPS_OFS_DATA;

   logic        clk, rst, supply_req, init_req, hs_ok, init_n, err;
   logic        psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb;
   logic        disp_on, mode_480, seg_remap, com_remap, scan_rev;
   logic [7:0]  contrast;
   logic [6:0]  start_line, col_addr;
   int          n_mismatch, check_count, n;

   ops_host_model u_host (.clk(clk), .rst(rst), .supply_req(supply_req), .init_req(init_req),
      .high_supply_ok(hs_ok), .init_n(init_n));

   ops_power_reset #(.HS_WAIT_CYC(HS), .DISCHARGE_CYC(DIS), .COLS(120)) DUT (
      .CORE_CLK(clk), .RST(rst), .ACTIVE_LOW_INIT_INPUT_N(init_n), .HIGH_SUPPLY_OK(hs_ok),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PSTRB(pstrb), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
      .DISPLAY_ON(disp_on), .MODE_480(mode_480), .SEG_REMAP(seg_remap), .COM_REMAP(com_remap),
      .SCAN_REV(scan_rev), .CONTRAST(contrast), .START_LINE(start_line), .COL_ADDR(col_addr));

   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic summarize();
      if (n_mismatch == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask

   // one transfer; waits for pready without assuming a count
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel    <= 1'h1;
      penable <= 1'h0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'h1;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (pready !== 1'h1 && i < 20);
      if (pready !== 1'h1) begin
         n_mismatch++;
         $display("[FAIL] %0t bus answer missing", $time);
         summarize();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask

   function automatic logic [31:0] outs();
      return 32'({disp_on, mode_480, seg_remap, com_remap, scan_rev, contrast, start_line, col_addr});
   endfunction

   task automatic set_cfg();
      apb(1'h1, A_CTRL, 32'h0000_001c);
      apb(1'h1, A_CON, 32'h0000_0020);
      apb(1'h1, A_ST, 32'h0000_0005);
      apb(1'h1, A_COL, 32'h0000_0010);
      cyc(2);
      chk(outs(), 32'({5'h07, 8'h20, 7'h05, 7'h10}), "config written");
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic s_defaults();
      chk(outs(), 32'({5'h08, 8'h7f, 14'h0000}), "pins after reset");
      apb(1'h0, A_CTRL, 32'h0000_0000);
      chk(rd, 32'h0000_0002, "ctrl after reset");
      apb(1'h0, A_CON, 32'h0000_0000);
      chk(rd, 32'h0000_007f, "contrast after reset");
      apb(1'h0, A_ST, 32'h0000_0000);
      chk(rd, 32'h0000_0000, "start line after reset");
      apb(1'h0, A_COL, 32'h0000_0000);
      chk(rd, 32'h0000_0000, "column after reset");
   endtask

   task automatic s_init_pin();
      set_cfg();
      init_req <= 1'h1;
      cyc(4);
      chk(outs(), 32'({5'h08, 8'h7f, 14'h0000}), "init pin low");
      apb(1'h1, A_CON, 32'h0000_0055);
      cyc(1);
      chk(32'(contrast), 32'h0000_007f, "write while held");
      init_req <= 1'h0;
      cyc(4);
      set_cfg();
      apb(1'h1, A_CTRL, 32'h0000_0020);
      cyc(3);
      chk(outs(), 32'({5'h08, 8'h7f, 14'h0000}), "soft reset");
   endtask

   task automatic s_power_up();
      apb(1'h1, A_CTRL, 32'h0000_0002);
      apb(1'h1, A_CTRL, 32'h0000_0003);
      cyc(2);
      chk(32'(disp_on), 32'h0000_0000, "on before high supply");
      apb(1'h0, A_STAT, 32'h0000_0000);
      chk(rd & 32'h0000_000b, 32'h0000_0008, "early on flag");
      supply_req <= 1'h1;
      n = 0;
      while (hs_ok !== 1'h1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      chk(32'(hs_ok), 32'h0000_0001, "high supply came up");
      n = 0;
      while (disp_on !== 1'h1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      chk(32'(n >= HS && n <= HS + 6), 32'h0000_0001, "on delay after supply");
      apb(1'h1, A_STAT, 32'h0000_0008);
      apb(1'h0, A_STAT, 32'h0000_0000);
      chk(rd, 32'h0000_0003, "status when on");
   endtask

   task automatic s_power_down();
      apb(1'h1, A_CTRL, 32'h0000_0002);
      cyc(2);
      chk(32'(disp_on), 32'h0000_0000, "off before supply drop");
      supply_req <= 1'h0;
      cyc(DIS / 2);
      apb(1'h0, A_STAT, 32'h0000_0000);
      chk(rd, 32'h0000_0000, "discharge too early");
      cyc(DIS + 4);
      apb(1'h0, A_STAT, 32'h0000_0000);
      chk(rd, 32'h0000_0004, "discharged");
   endtask

   task automatic s_bus_edges();
      apb(1'h0, 12'h018, 32'h0000_0000);
      chk({rd[31:1], err}, 32'h0000_0001, "unmapped read");
      pstrb <= 4'he;
      apb(1'h1, A_CON, 32'h0000_0011);
      pstrb <= 4'hf;
      cyc(1);
      chk(32'(contrast), 32'h0000_007f, "strobe off write");
      apb(1'h1, A_COL, 32'h0000_0076);
      apb(1'h1, A_DATA, 32'h0000_00aa);
      cyc(1);
      chk(32'(col_addr), 32'h0000_0077, "column advance");
      apb(1'h1, A_DATA, 32'h0000_0055);
      cyc(1);
      chk(32'(col_addr), 32'h0000_0000, "column wrap");
   endtask

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   initial begin
      rst = 1'h1;
      supply_req = 1'h0;
      init_req = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      pstrb = 4'hf;
      n_mismatch = 0;
      check_count = 0;
      repeat (20) @(posedge clk);
      rst <= 1'h0;
      cyc(5);
      s_defaults();
      s_init_pin();
      s_power_up();
      s_power_down();
      s_bus_edges();
      summarize();
   end
endmodule // tb_ops_power_reset

`default_nettype wire
